// ### verif/core_model.sv
// Core model that holds the live context and clobbers it in the routine.
`default_nettype none
module core_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic irq_entry,
  output var irq_wake_pkg::ctx_s core_ctx
);
  timeunit 1ns;
  timeprecision 1ps;
  // -----------------------------------------------
  // Live context
  // -----------------------------------------------
  // The routine overwrites every live register, so a restore must undo it.
  always_ff @(posedge clk) begin
    if (rst) begin
      core_ctx <= 64'h1122_3344_4455_5566;
    end else if (irq_entry) begin
      core_ctx <= ~core_ctx;
    end
  end
endmodule
`default_nettype wire

// ### verif/irq_wake_context_control_test.sv
// Self-checking bench for the interrupt, wake and context-save block.
`default_nettype none
`define CHK(nm, ex, sn) begin n_compared++; if ((sn) !== (ex)) begin error_cnt++; \
  $display("unexpected %s exp %h got %h", nm, ex, sn); end end
module irq_wake_context_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, core_sleep = 0, core_return_from_irq_instr = 0;
  logic [4:0] reg_addr = 5'h00;
  logic [7:0] reg_wdata = 8'h00, pins = 8'h00, pflags = 8'h00, reg_rdata;
  logic t0f = 0, pcf = 0;
  logic instr_q1, core_run, core_wake, irq_entry, ctx_restore;
  logic [15:0] irq_vector;
  irq_wake_pkg::ctx_s core_ctx, ctx_restored;
  int error_cnt = 0, n_compared = 0, n;
  // Design, with the core-group flags driven by the bench.
  irq_wake_context_control dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .ext_pins(pins), .timer0_overflow_flag(t0f), .pin_change_flag(pcf),
    .periph_flags_a(pflags), .core_sleep, .core_return_from_irq_instr, .core_ctx, .instr_q1, .core_run,
    .core_wake, .irq_entry, .irq_vector, .ctx_restore, .ctx_restored);
  core_model core (.clk, .rst, .irq_entry, .core_ctx);
  // Free-running 250 MHz clock.
  initial forever #2 clk = ~clk;
  // Prints the counts and the verdict, then ends the run.
  task report_and_stop;
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // One-cycle register write.
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // One-cycle register read; data is looked at in the cycle after.
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    `CHK("rdata", e, reg_rdata)
  endtask
  // Bounded wait for a wake pulse or an entry pulse; a hang ends the run.
  task automatic wt(input bit wk, output int c);
    c = 0;
    do begin
      @(posedge clk);
      #1;
      c++;
    end while (((wk ? core_wake : irq_entry) !== 1'b1) && c < 300);
    if ((wk ? core_wake : irq_entry) !== 1'b1) begin
      error_cnt++;
      $display("unexpected wait exp 1 got 0");
      report_and_stop;
    end
  endtask
  // No entry, or while asleep no run, may show for twenty cycles.
  task automatic quiet(input bit slp);
    repeat (20) begin
      @(posedge clk);
      #1;
      `CHK("idle", 1'b0, slp ? core_run : irq_entry)
    end
  endtask
  // Sleep pulse; the core must stop.
  task nap;
    @(posedge clk);
    core_sleep <= 1'b1;
    @(posedge clk);
    core_sleep <= 1'b0;
    #1;
    `CHK("run", 1'b0, core_run)
  endtask
  // -----------------------------------------------
  // Main sequence
  // -----------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    // Any eight cycles hold exactly two first-quarter pulses.
    n = 0;
    repeat (8) begin
      @(posedge clk);
      #1;
      n += instr_q1;
    end
    `CHK("q1", 2, n)
    rd(5'h00, 8'h01);
    rd(5'h01, 8'h00);
    wr(5'h00, 8'hff);
    rd(5'h00, 8'hc1);
    wr(5'h00, 8'h00);
    wr(5'h01, 8'hff);
    rd(5'h01, 8'h31);
    wr(5'h02, 8'ha5);
    rd(5'h02, 8'ha5);
    rd(5'h10, 8'h00);
    wr(5'h01, 8'h00);
    // The pin edge needs the synchroniser's cycles before the flag shows.
    pins <= 8'h01;
    repeat (4) @(posedge clk);
    rd(5'h03, 8'h01);
    wr(5'h03, 8'h00);
    pins <= 8'h00;
    repeat (4) @(posedge clk);
    rd(5'h03, 8'h00);
    wr(5'h01, 8'h01);
    wr(5'h00, 8'h80);
    pins <= 8'h01;
    wt(0, n);
    `CHK("vector", 16'h0004, irq_vector)
    rd(5'h00, 8'h01);
    rd(5'h18, 8'h11);
    rd(5'h19, 8'h22);
    rd(5'h1f, 8'h66);
    wr(5'h18, 8'h99);
    wr(5'h03, 8'h00);
    @(posedge clk) core_return_from_irq_instr <= 1'b1;
    @(posedge clk) core_return_from_irq_instr <= 1'b0;
    #1;
    `CHK("restore", 1'b1, ctx_restore)
    `CHK("w", 8'h99, ctx_restored.w)
    `CHK("status", 8'h3a, ctx_restored.status)
    `CHK("latch", 8'h66, ctx_restored.pc_high_latch)
    rd(5'h00, 8'h81);
    wr(5'h00, 8'h00);
    pins <= 8'h00;
    nap;
    pins <= 8'h01;
    wt(1, n);
    `CHK("run", 1'b1, core_run)
    quiet(0);
    wr(5'h03, 8'h00);
    pins <= 8'h00;
    wr(5'h00, 8'h80);
    nap;
    pins <= 8'h01;
    wt(1, n);
    wt(0, n);
    `CHK("step", 1'b1, n >= 4)
    wr(5'h03, 8'h00);
    wr(5'h02, 8'h01);
    pflags <= 8'h01;
    wr(5'h00, 8'h80);
    quiet(0);
    wr(5'h00, 8'hc0);
    wt(0, n);
    // Timer0 cannot wake the core; the pin-change source can.
    wr(5'h02, 8'h00);
    wr(5'h01, 8'h30);
    t0f <= 1'b1;
    rd(5'h03, 8'h20);
    nap;
    quiet(1);
    pcf <= 1'b1;
    wt(1, n);
    rd(5'h03, 8'h30);
    wr(5'h00, 8'h80);
    wt(0, n);
    report_and_stop;
  end
endmodule
`default_nettype wire

// ### verilog/ctx_if.sv
// Carrier between the control logic and the shadow register bank.
`default_nettype none
interface ctx_if;
  logic save;                      // Capture live context this cycle.
  logic restore;                   // Present shadow copies to the core.
  irq_wake_pkg::ctx_s live;        // Live core context.
  irq_wake_pkg::ctx_s restored;    // Context to reload, from shadows.
  logic wr;                        // Software write to one shadow byte.
  logic [2:0] idx;                 // Shadow byte index.
  logic [7:0] wdata;               // Software write data.
  logic [7:0] rdata;               // Shadow byte at idx.
  modport ctl (output save, restore, live, wr, idx, wdata, input restored, rdata);
  modport bank (input save, restore, live, wr, idx, wdata, output restored, rdata);
endinterface
`default_nettype wire

// ### verilog/ext_edge_detect.sv
// Synchroniser and selectable edge detector for the external pin.
`default_nettype none
`include "irq_wake_cfg.svh"
module ext_edge_detect (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin_async,
  input wire logic rise_sel,
  output logic edge_pulse
);
  logic meta_ff;   // First stage, read only by the second.
  logic sync_ff;   // Second stage, safe to use.
  logic prev_ff;   // Previous synchronised level.

  // -----------------------------------------------------------------
  // Two-stage synchroniser and history flop.
  // -----------------------------------------------------------------
  // Pin edges are asynchronous; they are resynchronised first.
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      meta_ff <= pin_async;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  // Rising edge when select is high, falling edge when low.
  always_comb begin
    if (rise_sel) begin
      edge_pulse = sync_ff & ~prev_ff;
    end else begin
      edge_pulse = ~sync_ff & prev_ff;
    end
  end
endmodule
`default_nettype wire

// ### verilog/irq_wake_cfg.svh
// Offsets, field positions, reset values and timing counts of the block.
`ifndef IRQ_WAKE_CFG_SVH
`define IRQ_WAKE_CFG_SVH
// Register offsets on the plain register port.
`define OFS_IRQ_CONTROL 5'h00
`define OFS_CORE_EN 5'h01
`define OFS_PERIPH_EN_A 5'h02
`define OFS_CORE_FLAGS 5'h03
`define OFS_PIN_SELECT 5'h04
// Shadow copies sit in the data bank 31 window: address bits 4:3 both set.
`define SHADOW_BANK 5'h1f
`define SHADOW_WINDOW 2'h3
// Field positions.
`define GIE_BIT 7
`define PERIPHERAL_IRQ_GATE_BIT 6
`define EDGE_BIT 0
`define T0_BIT 5
`define IOC_BIT 4
`define EXT_BIT 0
// Reset values.
`define EDGE_RST 1'b1
`define BYTE_ZERO 8'h00
`define SEL_RST 3'h0
// Instruction cycle: four clock phases, phase 0 is the first quarter.
`define Q_LAST 2'h3
`define Q_FIRST 2'h0
`define IRQ_VECTOR 16'h0004
// Status bits that are never saved or restored (timeout, power-down).
`define TOPD_MASK 8'h18
// Shadow byte indices.
`define SH_W 3'h0
`define SH_STATUS 3'h1
`define SH_BANK 3'h2
`define SH_IP0_LO 3'h3
`define SH_IP0_HI 3'h4
`define SH_IP1_LO 3'h5
`define SH_IP1_HI 3'h6
`define SH_PC_HIGH_LATCH 3'h7
`endif

// ### verilog/irq_wake_context_control.sv
// Interrupt gating, external pin, sleep wake and context save control.
//
// Behaviour
// - Enabled wake-capable sources set before sleep wake core.
// - Only clock-independent sources may wake core.
// - Wake: vector if global enable, else continue.
// - One instruction after sleep runs before vector.
// - External pin edge request, enabled by bit 0.
// - Edge select one rising, zero falling; here it is read-only and stays one.
// - Valid edge sets flag; enabled redirects.
// - Entry pushes return, shadows context except timeout/power-down bits.
// - Return reloads context from shadow copies.
// - Shadows live in bank 31, read/write.
// - Global enable bit 7, hardware set/clear, resets zero.
// - Peripheral gate bit 6 blocks peripheral requests.
// - Edge select resets to one; bits 5-1 zero.
// - External pin chosen by pin select register.
// - Second enable register holds eight peripheral enables.
// - Accept: flush, clear enable, push, save, vector.
// - Flags set regardless of any enable.
// - Return pops, restores, sets global enable.
// - Requests sampled in first quarter of cycle.
`default_nettype none
`include "irq_wake_cfg.svh"
module irq_wake_context_control #(
  parameter int PIN_COUNT = 8,
  parameter logic [7:0] ASYNC_SRC_MASK = 8'h00
) (
  input wire logic clk,
  input wire logic rst,
  // Register port.
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // External pins, one of which feeds the external interrupt.
  input wire logic [PIN_COUNT-1:0] ext_pins,
  // Peripheral request flags, held by the peripherals.
  input wire logic timer0_overflow_flag,
  input wire logic pin_change_flag,
  input wire logic [7:0] periph_flags_a,
  // Core sequencer side.
  input wire logic core_sleep,
  input wire logic core_return_from_irq_instr,
  input wire irq_wake_pkg::ctx_s core_ctx,
  output logic instr_q1,
  output logic core_run,
  output logic core_wake,
  output logic irq_entry,
  output logic [15:0] irq_vector,
  output logic ctx_restore,
  output irq_wake_pkg::ctx_s ctx_restored
);

  // -----------------------------------------------------------------
  // Declarations.
  // -----------------------------------------------------------------
  logic [1:0] q_cnt_ff;       // Phase within the instruction cycle.
  logic q1_en;                // First-quarter enable pulse.
  logic gie_ff;               // Global interrupt enable.
  logic peripheral_irq_gate_ff;              // Peripheral interrupt gate.
  logic edge_sel_ff;          // External edge select.
  logic [7:0] core_en_ff;     // Core-level enables.
  logic [7:0] periph_en_ff;   // First peripheral group enables.
  logic [2:0] pin_sel_ff;     // External pin selection.
  logic ext_flag_ff;          // External interrupt flag.
  logic ext_edge;             // Valid edge seen this cycle.
  logic sel_pin;              // Selected external pin level.
  logic [7:0] rdata_ff;       // Registered read data.
  logic irq_entry_ff;         // Entry pulse to the core.
  logic [15:0] vector_ff;     // Vector address to the core.
  logic restore_ff;           // Restore pulse to the core.
  logic step_ff;              // First Q1 after wake has passed.
  logic wake_ff;              // Wake pulse to the core.
  irq_wake_pkg::seq_state_e state_ff;
  irq_wake_pkg::seq_state_e nxt_state;
  logic [7:0] ctrl_rd;        // Control register as read.
  logic [7:0] flags_rd;       // Core flag register as read.
  logic periph_req;           // Gated peripheral request.
  logic core_req;             // Core-level request.
  logic pending;              // Request ready for the core.
  logic wake_src;             // Wake-capable enabled request.
  logic take;                 // Interrupt accepted this cycle.
  logic sw_wr_ctrl;           // Write to the control register.
  logic sw_wr_flags;          // Write to the flag register.
  logic sh_hit;               // Address in the shadow window.

  ctx_if cx ();

  // -----------------------------------------------------------------
  // Instruction cycle divider.
  // -----------------------------------------------------------------
  // Four clock phases make one instruction cycle.
  always_ff @(posedge clk) begin
    if (rst) begin
      q_cnt_ff <= `Q_FIRST;
    end else if (q_cnt_ff == `Q_LAST) begin
      q_cnt_ff <= `Q_FIRST;
    end else begin
      q_cnt_ff <= q_cnt_ff + 2'h1;
    end
  end

  // One-cycle enable in the first quarter.
  assign q1_en = (q_cnt_ff == `Q_FIRST);
  assign instr_q1 = q1_en;

  // -----------------------------------------------------------------
  // External pin path.
  // -----------------------------------------------------------------
  // The selected pin feeds the synchroniser; changing the selection
  // may itself look like an edge, so select before enabling.
  assign sel_pin = ext_pins[pin_sel_ff];

  ext_edge_detect u_edge (
    .clk(clk),
    .rst(rst),
    .pin_async(sel_pin),
    .rise_sel(edge_sel_ff),
    .edge_pulse(ext_edge)
  );

  // -----------------------------------------------------------------
  // Request gating.
  // -----------------------------------------------------------------
  // Flags combine with enables; peripherals pass the gate first.
  always_comb begin
    periph_req = peripheral_irq_gate_ff & (|(periph_flags_a & periph_en_ff));
    core_req = (ext_flag_ff & core_en_ff[`EXT_BIT])
             | (timer0_overflow_flag & core_en_ff[`T0_BIT])
             | (pin_change_flag & core_en_ff[`IOC_BIT]);
    pending = gie_ff & (core_req | periph_req);
  end

  // Only sources that run without the system clock may wake the core.
  always_comb begin
    wake_src = (ext_flag_ff & core_en_ff[`EXT_BIT])
             | (pin_change_flag & core_en_ff[`IOC_BIT])
             | (peripheral_irq_gate_ff & (|(periph_flags_a & periph_en_ff & ASYNC_SRC_MASK)));
  end

  // Accept only in the first quarter, when running or after the step.
  always_comb begin
    take = q1_en & pending
         & ((state_ff == irq_wake_pkg::ST_RUN)
         | ((state_ff == irq_wake_pkg::ST_STEP) & step_ff));
  end

  // -----------------------------------------------------------------
  // Sleep and wake sequencer.
  // -----------------------------------------------------------------
  // Wake goes straight on without global enable, else one step first.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      irq_wake_pkg::ST_RUN: begin
        if (core_sleep && !take) begin
          nxt_state = irq_wake_pkg::ST_SLEEP;
        end
      end
      irq_wake_pkg::ST_SLEEP: begin
        if (wake_src && gie_ff) begin
          nxt_state = irq_wake_pkg::ST_STEP;
        end else if (wake_src) begin
          nxt_state = irq_wake_pkg::ST_RUN;
        end
      end
      irq_wake_pkg::ST_STEP: begin
        if (q1_en && step_ff) begin
          nxt_state = irq_wake_pkg::ST_RUN;
        end
      end
      default: begin
        nxt_state = irq_wake_pkg::ST_RUN;
      end
    endcase
  end

  // State register.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= irq_wake_pkg::ST_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // The step flag marks the Q1 that starts the instruction after sleep.
  always_ff @(posedge clk) begin
    if (rst) begin
      step_ff <= 1'b0;
    end else if (state_ff != irq_wake_pkg::ST_STEP) begin
      step_ff <= 1'b0;
    end else if (q1_en) begin
      step_ff <= 1'b1;
    end
  end

  // One-cycle wake pulse when sleep ends.
  always_ff @(posedge clk) begin
    if (rst) begin
      wake_ff <= 1'b0;
    end else begin
      wake_ff <= (state_ff == irq_wake_pkg::ST_SLEEP) && wake_src;
    end
  end

  assign core_wake = wake_ff;
  assign core_run = (state_ff != irq_wake_pkg::ST_SLEEP);

  // -----------------------------------------------------------------
  // Entry and return towards the core.
  // -----------------------------------------------------------------
  // Entry: flush, push the return address and load the vector.
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_entry_ff <= 1'b0;
      vector_ff <= 16'h0000;
      restore_ff <= 1'b0;
    end else begin
      irq_entry_ff <= take;
      vector_ff <= `IRQ_VECTOR;
      restore_ff <= core_return_from_irq_instr;
    end
  end

  assign irq_entry = irq_entry_ff;
  assign irq_vector = vector_ff;
  assign ctx_restore = restore_ff;
  assign ctx_restored = cx.restored;

  // -----------------------------------------------------------------
  // Shadow bank connection.
  // -----------------------------------------------------------------
  // Context is captured in the accept cycle, before the core moves on.
  assign sh_hit = (reg_addr[4:3] == `SHADOW_WINDOW);
  assign cx.save = take;
  assign cx.restore = restore_ff;
  assign cx.live = core_ctx;
  assign cx.wr = reg_wr & sh_hit;
  assign cx.idx = reg_addr[2:0];
  assign cx.wdata = reg_wdata;

  shadow_context u_shadow (
    .clk(clk),
    .rst(rst),
    .cx(cx.bank)
  );

  // -----------------------------------------------------------------
  // Control register and enables.
  // -----------------------------------------------------------------
  assign sw_wr_ctrl = reg_wr && (reg_addr == `OFS_IRQ_CONTROL);
  assign sw_wr_flags = reg_wr && (reg_addr == `OFS_CORE_FLAGS);

  // Global enable: accept clears it, return sets it, else software.
  always_ff @(posedge clk) begin
    if (rst) begin
      gie_ff <= 1'b0;
    end else if (take) begin
      gie_ff <= 1'b0;
    end else if (core_return_from_irq_instr) begin
      gie_ff <= 1'b1;
    end else if (sw_wr_ctrl) begin
      gie_ff <= reg_wdata[`GIE_BIT];
    end
  end

  // Peripheral gate and edge select; edge select is read-only.
  always_ff @(posedge clk) begin
    if (rst) begin
      peripheral_irq_gate_ff <= 1'b0;
      edge_sel_ff <= `EDGE_RST;
    end else if (sw_wr_ctrl) begin
      peripheral_irq_gate_ff <= reg_wdata[`PERIPHERAL_IRQ_GATE_BIT];
    end
  end

  // Enable registers and pin selection.
  always_ff @(posedge clk) begin
    if (rst) begin
      core_en_ff <= `BYTE_ZERO;
      periph_en_ff <= `BYTE_ZERO;
      pin_sel_ff <= `SEL_RST;
    end else if (reg_wr) begin
      if (reg_addr == `OFS_CORE_EN) begin
        core_en_ff <= '0;
        core_en_ff[`T0_BIT] <= reg_wdata[`T0_BIT];
        core_en_ff[`IOC_BIT] <= reg_wdata[`IOC_BIT];
        core_en_ff[`EXT_BIT] <= reg_wdata[`EXT_BIT];
      end
      if (reg_addr == `OFS_PERIPH_EN_A) begin
        periph_en_ff <= reg_wdata;
      end
      if (reg_addr == `OFS_PIN_SELECT) begin
        pin_sel_ff <= reg_wdata[2:0];
      end
    end
  end

  // External flag: an edge sets it whatever the enables; set wins.
  always_ff @(posedge clk) begin
    if (rst) begin
      ext_flag_ff <= 1'b0;
    end else if (ext_edge) begin
      ext_flag_ff <= 1'b1;
    end else if (sw_wr_flags) begin
      ext_flag_ff <= reg_wdata[`EXT_BIT];
    end
  end

  // -----------------------------------------------------------------
  // Register read path.
  // -----------------------------------------------------------------
  // Read views; unimplemented bits read zero.
  always_comb begin
    ctrl_rd = `BYTE_ZERO;
    ctrl_rd[`GIE_BIT] = gie_ff;
    ctrl_rd[`PERIPHERAL_IRQ_GATE_BIT] = peripheral_irq_gate_ff;
    ctrl_rd[`EDGE_BIT] = edge_sel_ff;
    flags_rd = `BYTE_ZERO;
    flags_rd[`T0_BIT] = timer0_overflow_flag;
    flags_rd[`IOC_BIT] = pin_change_flag;
    flags_rd[`EXT_BIT] = ext_flag_ff;
  end

  // Data stands only in the cycle after the read strobe.
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff <= `BYTE_ZERO;
    end else if (!reg_rd) begin
      rdata_ff <= `BYTE_ZERO;
    end else if (sh_hit) begin
      rdata_ff <= cx.rdata;
    end else begin
      case (reg_addr)
        `OFS_IRQ_CONTROL: rdata_ff <= ctrl_rd;
        `OFS_CORE_EN: rdata_ff <= core_en_ff;
        `OFS_PERIPH_EN_A: rdata_ff <= periph_en_ff;
        `OFS_CORE_FLAGS: rdata_ff <= flags_rd;
        `OFS_PIN_SELECT: rdata_ff <= {5'h00, pin_sel_ff};
        default: rdata_ff <= `BYTE_ZERO;
      endcase
    end
  end

  assign reg_rdata = rdata_ff;

  // -----------------------------------------------------------------
  // Checks.
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  AST_ENTRY_NEEDS_GIE: assert property (irq_entry_ff |-> $past(gie_ff))
    else $error("Entry without global enable.");

  AST_ENTRY_CLEARS_GIE: assert property (take |=> !gie_ff && irq_entry_ff)
    else $error("Accept did not clear enable and signal entry.");

  AST_RETURN_FROM_IRQ_INSTR_SETS_GIE: assert property (core_return_from_irq_instr && !take |=> gie_ff && ctx_restore)
    else $error("Return did not set enable and restore.");

  AST_EDGE_SETS_FLAG: assert property (ext_edge |=> ext_flag_ff)
    else $error("Edge did not set the external flag.");

  AST_TAKE_IN_Q1: assert property (take |-> q_cnt_ff == `Q_FIRST)
    else $error("Interrupt accepted outside the first quarter.");

  AST_PERIPHERAL_IRQ_GATE_GATES: assert property (take && !peripheral_irq_gate_ff |-> core_req)
    else $error("Peripheral request passed a closed gate.");

  AST_STEP_FIRST: assert property (
    state_ff == irq_wake_pkg::ST_SLEEP && nxt_state == irq_wake_pkg::ST_STEP
    |=> !take [*4])
    else $error("Vector taken before the instruction after sleep.");

  AST_SLEEP_HOLDS: assert property (
    state_ff == irq_wake_pkg::ST_SLEEP && !wake_src |=> state_ff == irq_wake_pkg::ST_SLEEP)
    else $error("Core woke without an enabled source.");

  AST_NO_GIE_RESUME: assert property (
    state_ff == irq_wake_pkg::ST_SLEEP && wake_src && !gie_ff
    |=> state_ff == irq_wake_pkg::ST_RUN && core_wake)
    else $error("Wake without enable did not resume.");

endmodule
`default_nettype wire

// ### verilog/irq_wake_pkg.sv
// Types shared by the interrupt, wake and context-save logic.
`default_nettype none
package irq_wake_pkg;
  // Core context that is saved on entry and restored on return.
  typedef struct packed {
    logic [7:0] w;
    logic [7:0] status;
    logic [7:0] bank_select;
    logic [15:0] indirect_pointer0;
    logic [15:0] indirect_pointer1;
    logic [7:0] pc_high_latch;
  } ctx_s;
  // Sequencer states: running, sleeping, one instruction after wake.
  typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_STEP} seq_state_e;
endpackage
`default_nettype wire

// ### verilog/shadow_context.sv
// Shadow register bank: context save, restore and software access.
`default_nettype none
`include "irq_wake_cfg.svh"
module shadow_context (
  input wire logic clk,
  input wire logic rst,
  ctx_if.bank cx
);
  logic [7:0] mem_ff [8];  // Shadow bytes, indexed by `SH_* codes.
  logic [7:0] live_b [8];  // Live context split into bytes.

  // Live context as bytes; status keeps its shadow timeout/power-down.
  always_comb begin
    live_b[`SH_W] = cx.live.w;
    live_b[`SH_STATUS] = (cx.live.status & ~`TOPD_MASK)
                       | (mem_ff[`SH_STATUS] & `TOPD_MASK);
    live_b[`SH_BANK] = cx.live.bank_select;
    live_b[`SH_IP0_LO] = cx.live.indirect_pointer0[7:0];
    live_b[`SH_IP0_HI] = cx.live.indirect_pointer0[15:8];
    live_b[`SH_IP1_LO] = cx.live.indirect_pointer1[7:0];
    live_b[`SH_IP1_HI] = cx.live.indirect_pointer1[15:8];
    live_b[`SH_PC_HIGH_LATCH] = cx.live.pc_high_latch;
  end

  // -----------------------------------------------------------------
  // Shadow storage.
  // -----------------------------------------------------------------
  // Entry save overrides a software write in the same cycle.
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) begin
        mem_ff[i] <= `BYTE_ZERO;
      end
    end else if (cx.save) begin
      for (int i = 0; i < 8; i++) begin
        mem_ff[i] <= live_b[i];
      end
    end else if (cx.wr) begin
      mem_ff[cx.idx] <= cx.wdata;
    end
  end

  // Reload values; the live timeout/power-down bits pass through.
  always_comb begin
    cx.rdata = mem_ff[cx.idx];
    cx.restored.w = mem_ff[`SH_W];
    cx.restored.status = (mem_ff[`SH_STATUS] & ~`TOPD_MASK)
                       | (cx.live.status & `TOPD_MASK);
    cx.restored.bank_select = mem_ff[`SH_BANK];
    cx.restored.indirect_pointer0 = {mem_ff[`SH_IP0_HI], mem_ff[`SH_IP0_LO]};
    cx.restored.indirect_pointer1 = {mem_ff[`SH_IP1_HI], mem_ff[`SH_IP1_LO]};
    cx.restored.pc_high_latch = mem_ff[`SH_PC_HIGH_LATCH];
  end

  // Restore never brings back a stale timeout or power-down bit.
  AST_TOPD_FROM_LIVE: assert property (@(posedge clk) disable iff (rst)
    cx.restore |-> ((cx.restored.status & `TOPD_MASK) == (cx.live.status & `TOPD_MASK)))
    else $error("Restored status carries shadow timeout or power-down bits.");
endmodule
`default_nettype wire
